/* File: core/upi_device.sv */
// UART device end: multiplexed bus slave, modem pins, IR idle, reset
// What this block does
// - Access starts at chip select falling edge
// - Address captured at latch strobe rising edge
// - After latch strobe high, data phase begins
// - Interrupt driven when control bit3, else floating
// - Standard mode transmit idles high
// - Infrared mode idle level is low
// - Far end idles receive per mode
// - Host asserts request-to-send before auto flow
// - Request-to-send doubles as RS-485 direction
// - Clear-to-send is input or auto flow
// - Modem pins active low, general purpose use
// - Power save isolates host data bus
// - Reset pulse restores registers and outputs
// - During reset transmit high, receive ignored
// - Read falling edge drives addressed byte
// - Write rising edge stores bus byte
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module upi_device
  import upi_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  upi_if.device     pins,
  output logic [7:0] tx_data_out,
  output logic       tx_start_out,
  output logic [7:0] rx_data_out,
  output logic       rx_valid_out
);
  logic       rst_all;
  logic       rd_fall, rd_rise, wr_fall, wr_rise, la_fall, la_rise, cs_fall, cs_rise;
  logic       bus_en;
  logic       in_access_q, data_phase_q;
  logic [7:0] addr_q;
  logic [7:0] ien_q, mctl_q, xfeat_q, fctl_q, xmode_q, mstat_q;
  logic       tx_pend_q;
  logic [7:0] ad_out_q;
  logic       ad_oe_q;
  logic [7:0] tx_shift_q;
  logic [3:0] tx_cnt_q;
  logic [7:0] tx_div_q;
  logic       tx_busy_q;
  logic [7:0] rx_shift_q;
  logic [3:0] rx_cnt_q;
  logic [7:0] rx_div_q;
  logic       rx_busy_q;
  logic       rx_full_q;
  logic       rx_line;
  logic       tx_bit;
  logic       ir_mode;

  // Pin reset shares the async path with the system reset
  assign rst_all = rst_in | ~pins.reset_n;
  // Bus is isolated while power save is high
  assign bus_en  = ~pins.power_save;
  assign ir_mode = mctl_q[MCTL_IR_BIT];

  upi_edge u_rd (.sys_clk_in(sys_clk_in), .rst_in(rst_all), .sig_in(pins.read_strobe_n),
                 .fall_out(rd_fall), .rise_out(rd_rise));
  upi_edge u_wr (.sys_clk_in(sys_clk_in), .rst_in(rst_all), .sig_in(pins.write_strobe_n),
                 .fall_out(wr_fall), .rise_out(wr_rise));
  upi_edge u_la (.sys_clk_in(sys_clk_in), .rst_in(rst_all), .sig_in(pins.address_latch_strobe_n),
                 .fall_out(la_fall), .rise_out(la_rise));
  upi_edge u_cs (.sys_clk_in(sys_clk_in), .rst_in(rst_all), .sig_in(pins.cs_n),
                 .fall_out(cs_fall), .rise_out(cs_rise));

  // Access framing
  always_ff @(posedge sys_clk_in or posedge rst_all) begin
    if (rst_all) begin
      in_access_q  <= 1'b0;
      data_phase_q <= 1'b0;
      addr_q       <= REG_RESET;
    end else if (!bus_en || cs_rise || pins.cs_n) begin
      in_access_q  <= 1'b0;
      data_phase_q <= 1'b0;
    end else begin
      if (cs_fall) begin
        in_access_q  <= 1'b1;
        data_phase_q <= 1'b0;
      end
      if (la_fall) begin
        data_phase_q <= 1'b0;
      end
      if (la_rise) begin
        addr_q       <= pins.ad_host;
        data_phase_q <= 1'b1;
      end
    end
  end

  // Register writes on write strobe rising edge
  always_ff @(posedge sys_clk_in or posedge rst_all) begin
    if (rst_all) begin
      ien_q   <= REG_RESET;
      mctl_q  <= REG_RESET;
      xfeat_q <= REG_RESET;
      fctl_q  <= REG_RESET;
      xmode_q <= REG_RESET;
    end else if (bus_en && in_access_q && data_phase_q && !pins.cs_n && wr_rise) begin
      unique case (addr_q)
        ADDR_IEN:   ien_q   <= pins.ad_host;
        ADDR_MCTL:  mctl_q  <= pins.ad_host;
        ADDR_XFEAT: xfeat_q <= pins.ad_host;
        ADDR_FCTL:  fctl_q  <= pins.ad_host;
        ADDR_XMODE: xmode_q <= pins.ad_host;
        default:   ;
      endcase
    end
  end

  // Modem status: active-low inputs shown as true bits
  always_ff @(posedge sys_clk_in or posedge rst_all) begin
    if (rst_all) begin
      mstat_q <= REG_RESET;
    end else begin
      mstat_q <= {~pins.cd_n, ~pins.ri_n, ~pins.dsr_n, ~pins.cts_n, 4'h0};
    end
  end

  // Read data fetched on the read strobe falling edge, held until rising edge
  always_ff @(posedge sys_clk_in or posedge rst_all) begin
    if (rst_all) begin
      ad_out_q <= REG_RESET;
      ad_oe_q  <= 1'b0;
    end else if (!bus_en || pins.cs_n) begin
      ad_oe_q  <= 1'b0;
    end else if (in_access_q && data_phase_q && rd_fall) begin
      ad_oe_q  <= 1'b1;
      unique case (addr_q)
        ADDR_DATA: ad_out_q <= rx_shift_q;
        ADDR_IEN:   ad_out_q <= ien_q;
        ADDR_MCTL:  ad_out_q <= mctl_q;
        ADDR_MSTAT: ad_out_q <= mstat_q;
        ADDR_XFEAT: ad_out_q <= xfeat_q;
        ADDR_FCTL:  ad_out_q <= fctl_q;
        ADDR_XMODE: ad_out_q <= xmode_q;
        default:   ad_out_q <= REG_RESET;
      endcase
    end else if (rd_rise) begin
      ad_oe_q  <= 1'b0;
    end
  end
  assign pins.ad_dev    = ad_out_q;
  assign pins.ad_dev_oe = ad_oe_q;

  // Transmitter: 8N1, a write to the data address loads a byte that waits for clear-to-send when auto clear-to-send is on
  // A write while a frame is on the line is lost: there is no buffer
  always_ff @(posedge sys_clk_in or posedge rst_all) begin
    if (rst_all) begin
      tx_shift_q <= 8'hFF;
      tx_cnt_q   <= 4'h0;
      tx_div_q   <= 8'h00;
      tx_busy_q  <= 1'b0;
      tx_pend_q  <= 1'b0;
      tx_bit     <= 1'b1;
    end else if (!tx_busy_q) begin
      tx_bit <= 1'b1;
      if (bus_en && data_phase_q && wr_rise && !pins.cs_n && addr_q == ADDR_DATA) begin
        tx_shift_q <= pins.ad_host;
        tx_pend_q  <= 1'b1;
      end else if (tx_pend_q && !(xfeat_q[XFEAT_ACTS_BIT] && pins.cts_n)) begin
        tx_pend_q  <= 1'b0;
        tx_busy_q  <= 1'b1;
        tx_cnt_q   <= 4'h0;
        tx_div_q   <= BAUD_DIV;
        tx_bit     <= 1'b0;
      end
    end else if (tx_div_q != 8'h01) begin
      tx_div_q <= tx_div_q - 8'h01;
    end else begin
      tx_div_q <= BAUD_DIV;
      tx_cnt_q <= tx_cnt_q + 4'h1;
      if (tx_cnt_q == 4'h8) begin
        tx_bit <= 1'b1;
      end else if (tx_cnt_q == 4'h9) begin
        tx_busy_q <= 1'b0;
      end else begin
        tx_bit     <= tx_shift_q[0];
        tx_shift_q <= {1'b1, tx_shift_q[7:1]};
      end
    end
  end
  // Standard: idle high; IR: a low idle, pulse for each zero bit
  assign pins.tx    = ir_mode ? (tx_busy_q & ~tx_bit & (tx_div_q > (BAUD_DIV >> 1))) : tx_bit;
  assign tx_data_out  = tx_shift_q;
  assign tx_start_out = tx_busy_q;

  // Receiver: IR input is inverted so the shared path sees high idle
  assign rx_line = ir_mode ? ~pins.rx : pins.rx;
  always_ff @(posedge sys_clk_in or posedge rst_all) begin
    if (rst_all) begin
      rx_shift_q <= REG_RESET;
      rx_cnt_q   <= 4'h0;
      rx_div_q   <= 8'h00;
      rx_busy_q  <= 1'b0;
      rx_full_q  <= 1'b0;
    end else begin
      if (bus_en && data_phase_q && rd_fall && addr_q == ADDR_DATA) begin
        rx_full_q <= 1'b0;
      end
      if (!rx_busy_q) begin
        if (!rx_line) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= 4'h0;
          rx_div_q  <= {1'b0, BAUD_DIV[7:1]};
        end
      end else if (rx_div_q != 8'h01) begin
        rx_div_q <= rx_div_q - 8'h01;
      end else begin
        rx_div_q <= BAUD_DIV;
        rx_cnt_q <= rx_cnt_q + 4'h1;
        if (rx_cnt_q == 4'h9) begin
          rx_busy_q <= 1'b0;
          rx_full_q <= 1'b1;
        end else if (rx_cnt_q != 4'h0) begin
          rx_shift_q <= {rx_line, rx_shift_q[7:1]};
        end
      end
    end
  end
  assign rx_data_out  = rx_shift_q;
  assign rx_valid_out = rx_full_q;

  // Interrupt is driven only when the enable bit is set
  assign pins.irq    = ien_q[IEN_RX_BIT] & rx_full_q;
  assign pins.irq_oe = mctl_q[MCTL_INT_OE_BIT];
  // RTS: RS-485 direction mode, else auto flow or plain output
  always_comb begin
    if (fctl_q[FCTL_485_BIT] || xmode_q[XMODE_485_BIT]) begin
      pins.rts_n = ~tx_busy_q;
    end else if (xfeat_q[XFEAT_ARTS_BIT]) begin
      pins.rts_n = ~mctl_q[MCTL_RTS_BIT] | rx_full_q;
    end else begin
      pins.rts_n = ~mctl_q[MCTL_RTS_BIT];
    end
  end
  assign pins.dtr_n = ~mctl_q[MCTL_DTR_BIT];
endmodule : upi_device

/* File: shared/upi_pkg.sv */
// Package of constants and types shared by the pin-level UART ends
package upi_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned RESET_MIN_NS    = 40;
  // Least time rounds up, never below one cycle
  localparam int unsigned RESET_MIN_CYC_I = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  RESET_MIN_CYC   = 4'(RESET_MIN_CYC_I < 1 ? 1 : RESET_MIN_CYC_I);
  // Baud divider: one bit per this many clocks, fixed plain default
  localparam logic [7:0]  BAUD_DIV        = 8'h10;
  // Register addresses on the multiplexed bus
  localparam logic [7:0]  ADDR_DATA       = 8'h00;
  localparam logic [7:0]  ADDR_IEN        = 8'h01;
  localparam logic [7:0]  ADDR_MCTL       = 8'h04;
  localparam logic [7:0]  ADDR_MSTAT      = 8'h06;
  localparam logic [7:0]  ADDR_XFEAT      = 8'h08;
  localparam logic [7:0]  ADDR_FCTL       = 8'h09;
  localparam logic [7:0]  ADDR_XMODE      = 8'h0A;
  // Field positions
  localparam int unsigned MCTL_DTR_BIT    = 0;
  localparam int unsigned MCTL_RTS_BIT    = 1;
  localparam int unsigned MCTL_INT_OE_BIT = 3;
  localparam int unsigned MCTL_IR_BIT     = 6;
  localparam int unsigned XFEAT_ARTS_BIT  = 6;
  localparam int unsigned XFEAT_ACTS_BIT  = 7;
  localparam int unsigned IEN_RX_BIT      = 0;
  localparam int unsigned IEN_RTS_BIT     = 6;
  localparam int unsigned IEN_CTS_BIT     = 7;
  localparam int unsigned FCTL_485_BIT    = 3;
  localparam int unsigned XMODE_485_BIT   = 3;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  // Controller register offsets on its software port
  localparam logic [3:0]  C_ADDR          = 4'h0;
  localparam logic [3:0]  C_WDATA         = 4'h1;
  localparam logic [3:0]  C_CMD           = 4'h2;
  localparam logic [3:0]  C_RDATA         = 4'h3;
  localparam logic [3:0]  C_STAT          = 4'h4;
  localparam logic [3:0]  C_MASK          = 4'h5;
  localparam logic [3:0]  C_CTRL          = 4'h6;
  localparam int unsigned ST_DONE_BIT     = 0;
  localparam int unsigned ST_INT_BIT      = 1;
  localparam logic [3:0]  PHASE_CYC       = 4'h2;
  typedef enum logic [2:0] {
    UPI_IDLE  = 3'b000,
    UPI_ALE   = 3'b001,
    UPI_ALEH  = 3'b010,
    UPI_STRB  = 3'b011,
    UPI_STRBH = 3'b100,
    UPI_END   = 3'b101
  } upi_state_t;
endpackage : upi_pkg

/* File: shared/upi_if.sv */
// Pin bundle between the host controller and the UART device
`timescale 1ns/1ns
interface upi_if;
  logic       cs_n;
  logic       address_latch_strobe_n;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic [7:0] ad_host;
  logic       ad_host_oe;
  logic [7:0] ad_dev;
  logic       ad_dev_oe;
  logic       irq;
  logic       irq_oe;
  logic       tx;
  logic       rx;
  logic       rts_n;
  logic       cts_n;
  logic       dtr_n;
  logic       dsr_n;
  logic       cd_n;
  logic       ri_n;
  logic       power_save;
  logic       reset_n;
  modport device (
    input  cs_n, address_latch_strobe_n, read_strobe_n, write_strobe_n, ad_host, ad_host_oe,
    input  rx, cts_n, dsr_n, cd_n, ri_n, power_save, reset_n,
    output ad_dev, ad_dev_oe, irq, irq_oe, tx, rts_n, dtr_n
  );
  modport host (
    output cs_n, address_latch_strobe_n, read_strobe_n, write_strobe_n, ad_host, ad_host_oe,
    output rx, cts_n, dsr_n, cd_n, ri_n, power_save, reset_n,
    input  ad_dev, ad_dev_oe, irq, irq_oe, tx, rts_n, dtr_n
  );
endinterface : upi_if

/* File: core/upi_edge.sv */
// Registered edge detector for one strobe pin
`timescale 1ns/1ns
module upi_edge (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic sig_in,
  output logic      fall_out,
  output logic      rise_out
);
  logic prev_q;
  // Idle strobes are high, so start high to avoid a false edge
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= sig_in;
    end
  end
  assign fall_out = prev_q & ~sig_in;
  assign rise_out = ~prev_q & sig_in;
endmodule : upi_edge

/* File: core/upi_host.sv */
// Host controller end: runs multiplexed bus cycles from a software port
`timescale 1ns/1ns
module upi_host
  import upi_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  upi_if.host             pins,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic [7:0]      rdata_out,
  output logic            irq_out
);
  upi_state_t st_q;
  logic [7:0] addr_q, wdata_q, rdata_q, stat_q, mask_q, ctrl_q, cap_q;
  logic       is_rd_q;
  logic [3:0] cnt_q;
  logic       ev_done, ev_int, go;
  logic       dev_irq;

  assign go      = wr_in && addr_in == C_CMD && st_q == UPI_IDLE;
  assign dev_irq = pins.irq_oe & pins.irq;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_q  <= 8'h00;
      wdata_q <= 8'h00;
      mask_q  <= 8'h00;
      ctrl_q  <= 8'h00;
    end else if (wr_in) begin
      if (addr_in == C_ADDR)  addr_q  <= wdata_in;
      if (addr_in == C_WDATA) wdata_q <= wdata_in;
      if (addr_in == C_MASK)  mask_q  <= wdata_in;
      if (addr_in == C_CTRL)  ctrl_q  <= wdata_in;
    end
  end

  // Bus sequencer: chip select, address latch, strobe, release
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q    <= UPI_IDLE;
      cnt_q   <= 4'h0;
      is_rd_q <= 1'b0;
      cap_q   <= 8'h00;
    end else if (st_q != UPI_IDLE && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      cnt_q <= PHASE_CYC;
      unique case (st_q)
        UPI_IDLE: if (go) begin
          st_q    <= UPI_ALE;
          is_rd_q <= wdata_in[0];
        end
        UPI_ALE:   st_q <= UPI_ALEH;
        UPI_ALEH:  st_q <= UPI_STRB;
        UPI_STRB:  st_q <= UPI_STRBH;
        UPI_STRBH: begin
          st_q  <= UPI_END;
          cap_q <= pins.ad_dev;
        end
        UPI_END:   st_q <= UPI_IDLE;
        default:   st_q <= UPI_IDLE;
      endcase
    end
  end
  assign ev_done = st_q == UPI_END && cnt_q == 4'h0;

  assign pins.cs_n                   = st_q == UPI_IDLE;
  assign pins.address_latch_strobe_n = st_q != UPI_ALE;
  assign pins.read_strobe_n          = !(is_rd_q && st_q == UPI_STRB);
  assign pins.write_strobe_n         = !(!is_rd_q && st_q == UPI_STRB);
  // Address is held past the latch strobe's rise, where the device samples it
  assign pins.ad_host                = (st_q == UPI_ALE || st_q == UPI_ALEH) ? addr_q : wdata_q;
  assign pins.ad_host_oe             = st_q == UPI_ALE || st_q == UPI_ALEH || (!is_rd_q && st_q != UPI_IDLE);
  // Serial and modem side levels, power save and pin reset driven from the control register
  assign pins.rx         = ctrl_q[1] ? 1'b0 : 1'b1;
  assign pins.cts_n      = ~ctrl_q[2];
  assign pins.dsr_n      = ~ctrl_q[3];
  assign pins.cd_n       = ~ctrl_q[4];
  assign pins.ri_n       = ~ctrl_q[5];
  assign pins.power_save = ctrl_q[6];
  assign pins.reset_n    = ~ctrl_q[0];

  // Sticky status, set wins over write-one clear
  logic dev_irq_q;
  assign ev_int = dev_irq & ~dev_irq_q;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_q    <= 8'h00;
      dev_irq_q <= 1'b0;
      rdata_q   <= 8'h00;
    end else begin
      dev_irq_q <= dev_irq;
      stat_q[ST_DONE_BIT] <= ev_done | (stat_q[ST_DONE_BIT] & ~(wr_in && addr_in == C_STAT && wdata_in[ST_DONE_BIT]));
      stat_q[ST_INT_BIT]  <= ev_int | (stat_q[ST_INT_BIT] & ~(wr_in && addr_in == C_STAT && wdata_in[ST_INT_BIT]));
      if (rd_in) begin
        unique case (addr_in)
          C_ADDR:  rdata_q <= addr_q;
          C_WDATA: rdata_q <= wdata_q;
          C_RDATA: rdata_q <= cap_q;
          C_STAT:  rdata_q <= stat_q;
          C_MASK:  rdata_q <= mask_q;
          C_CTRL:  rdata_q <= ctrl_q;
          default: rdata_q <= {5'h00, st_q};
        endcase
      end
    end
  end
  assign rdata_out = rdata_q;
  // A set mask bit silences its status bit
  assign irq_out   = |(stat_q & ~mask_q);
endmodule : upi_host

/* File: bench/upi_asserts.sv */
// Concurrent checks on the pin bundle joining host and device ends
`timescale 1ns/1ns
module upi_asserts (
  input wire logic       sys_clk_in,
  input wire logic       rst_in,
  input wire logic       cs_n,
  input wire logic       address_latch_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic [7:0] ad_host,
  input wire logic       ad_host_oe,
  input wire logic       ad_dev_oe,
  input wire logic       irq_oe,
  input wire logic       tx,
  input wire logic       rts_n,
  input wire logic       dtr_n,
  input wire logic       power_save,
  input wire logic       reset_n
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_strobe_in_cs: assert property ((!read_strobe_n || !write_strobe_n) |-> !cs_n)
    else $error("strobe outside chip select");
  a_cycle_len: assert property ($fell(cs_n) |-> (!cs_n) [*8])
    else $error("bus cycle too short");
  a_addr_driven: assert property (!address_latch_strobe_n |-> ad_host_oe && !cs_n)
    else $error("address not driven during latch");
  a_data_phase: assert property (($fell(read_strobe_n) || $fell(write_strobe_n)) |->
    $past(address_latch_strobe_n) && $past(address_latch_strobe_n, 3))
    else $error("strobe before address phase ended");
  a_no_clash: assert property (!(ad_host_oe && ad_dev_oe))
    else $error("both ends drive the bus");
  a_read_drive: assert property ($fell(read_strobe_n) && !power_save && reset_n |-> ##[1:3] ad_dev_oe)
    else $error("read data not driven");
  a_write_quiet: assert property (!write_strobe_n |-> !ad_dev_oe)
    else $error("device drives during write");
  a_write_held: assert property (!write_strobe_n && !$past(write_strobe_n) |-> ad_host_oe && $stable(ad_host))
    else $error("write data moved");
  a_float_idle: assert property (cs_n && $past(cs_n) |-> !ad_dev_oe)
    else $error("bus driven while not selected");
  a_save_float: assert property (power_save && $past(power_save) |-> !ad_dev_oe)
    else $error("bus driven in power save");
  a_reset_out: assert property (!reset_n |-> tx && rts_n && dtr_n && !irq_oe && !ad_dev_oe)
    else $error("output not at default in reset");
  a_tx_rest: assert property ($rose(reset_n) |-> tx [*2])
    else $error("transmit not idle after reset");
endmodule : upi_asserts

/* File: bench/tb.sv */
// Self-checking bench joining host and device ends over the pin bundle
`timescale 1ns/1ns
module tb
  import upi_pkg::*;
;
  logic       sys_clk_in;
  logic       rst_in;
  logic [3:0] addr_in;
  logic [7:0] wdata_in;
  logic       wr_in;
  logic       rd_in;
  logic [7:0] rdata_out;
  logic       irq_out;
  logic [7:0] rx_data_out;
  logic       rx_valid_out;
  int         fail_count;
  int         checked;
  logic [7:0] v;
  logic [7:0] r;
  logic       rts;
  logic [7:0] wregs [4] = '{ADDR_IEN, ADDR_XFEAT, ADDR_FCTL, ADDR_XMODE};
  upi_if upi_if_i ();
  upi_host upi_host_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .pins(upi_if_i.host), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out));
  upi_device upi_device_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .pins(upi_if_i.device), .tx_data_out(),
    .tx_start_out(), .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out));
  upi_asserts upi_asserts_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cs_n(upi_if_i.cs_n),
    .address_latch_strobe_n(upi_if_i.address_latch_strobe_n), .read_strobe_n(upi_if_i.read_strobe_n),
    .write_strobe_n(upi_if_i.write_strobe_n), .ad_host(upi_if_i.ad_host), .ad_host_oe(upi_if_i.ad_host_oe),
    .ad_dev_oe(upi_if_i.ad_dev_oe), .irq_oe(upi_if_i.irq_oe), .tx(upi_if_i.tx), .rts_n(upi_if_i.rts_n),
    .dtr_n(upi_if_i.dtr_n), .power_save(upi_if_i.power_save), .reset_n(upi_if_i.reset_n));
  always #25 sys_clk_in = ~sys_clk_in;
  function automatic logic [7:0] pin_flags();
    return {3'h0, rx_valid_out, upi_if_i.tx, upi_if_i.rts_n, upi_if_i.dtr_n, upi_if_i.irq_oe};
  endfunction : pin_flags
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : cyc
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // Strobe is lowered and one edge passes, so back-to-back calls never assign it twice in one step
  task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    cyc(1);
    wr_in <= 1'b0;
    cyc(1);
  endtask : sw_wr
  task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    cyc(1);
    rd_in <= 1'b0;
    cyc(1);
    d = rdata_out;
  endtask : sw_rd
  task automatic dev_acc(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] s;
    int n;
    s = 8'h00;
    n = 0;
    sw_wr(C_ADDR, a);
    sw_wr(C_WDATA, d);
    sw_wr(C_CMD, {7'h00, rd});
    while (s[ST_DONE_BIT] !== 1'b1 && n < 60) begin
      sw_rd(C_STAT, s);
      n++;
    end
    if (n >= 60) begin
      fail_count++;
      conclude();
    end
    sw_wr(C_STAT, 8'h01);
    sw_rd(C_RDATA, q);
  endtask : dev_acc
  task automatic get_frame(output logic [7:0] b, output logic rt);
    int n;
    n = 0;
    while (upi_if_i.tx !== 1'b0 && n < 2000) begin
      cyc(1);
      n++;
    end
    if (n >= 2000) begin
      fail_count++;
      conclude();
    end
    cyc(BAUD_DIV / 2);
    rt = upi_if_i.rts_n;
    for (int i = 0; i < 8; i++) begin
      cyc(BAUD_DIV);
      b[i] = upi_if_i.tx;
    end
    cyc(BAUD_DIV);
    chk({7'h00, upi_if_i.tx}, 8'h01);
  endtask : get_frame
  // Receive line is bit-banged through the control register, start bit first, LSB first
  task automatic put_frame(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      sw_wr(C_CTRL, {6'h00, ~f[i], 1'b0});
      cyc(BAUD_DIV - 2);
    end
  endtask : put_frame
  initial begin
    repeat (90000) @(posedge sys_clk_in);
    fail_count++;
    conclude();
  end
  initial begin
    sys_clk_in = 1'b0;
    rst_in = 1'b1;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    fail_count = 0;
    checked = 0;
    v = 8'($urandom(66292));
    cyc(8);
    rst_in <= 1'b0;
    cyc(1);
    chk(pin_flags(), 8'h0E);
    for (int k = 0; k < 5; k++) begin
      dev_acc(1'b1, k == 4 ? ADDR_MCTL : wregs[k], 8'h00, r);
      chk(r, REG_RESET);
    end
    for (int k = 0; k < 14; k++) begin
      v = k < 2 ? {8{k[0]}} : 8'($urandom());
      dev_acc(1'b0, wregs[k % 4], v, r);
      dev_acc(1'b1, wregs[k % 4], 8'h00, r);
      chk(r, v);
    end
    for (int k = 0; k < 4; k++) begin
      dev_acc(1'b0, wregs[k], 8'h00, r);
    end
    dev_acc(1'b1, 8'h0F, 8'h00, r);
    chk(r, 8'h00);
    dev_acc(1'b0, ADDR_MCTL, 8'h0B, r);
    chk(pin_flags(), 8'h09);
    dev_acc(1'b0, ADDR_MCTL, 8'h00, r);
    chk(pin_flags(), 8'h0E);
    sw_wr(C_CTRL, 8'h02);
    dev_acc(1'b0, ADDR_MCTL, 8'h40, r);
    cyc(3 * BAUD_DIV);
    chk(pin_flags(), 8'h06);
    dev_acc(1'b0, ADDR_MCTL, 8'h00, r);
    sw_wr(C_CTRL, 8'h04);
    dev_acc(1'b1, ADDR_MSTAT, 8'h00, r);
    chk({7'h00, r[4]}, 8'h01);
    // Auto clear-to-send holds the frame until the input is asserted
    sw_wr(C_CTRL, 8'h00);
    dev_acc(1'b0, ADDR_XFEAT, 8'h80, r);
    dev_acc(1'b0, ADDR_FCTL, 8'h08, r);
    dev_acc(1'b0, ADDR_XMODE, 8'h08, r);
    v = 8'($urandom());
    dev_acc(1'b0, ADDR_DATA, v, r);
    cyc(3 * BAUD_DIV);
    chk({7'h00, upi_if_i.tx}, 8'h01);
    sw_wr(C_CTRL, 8'h04);
    get_frame(r, rts);
    chk(r, v);
    chk({7'h00, rts}, 8'h00);
    cyc(BAUD_DIV);
    chk({7'h00, upi_if_i.rts_n}, 8'h01);
    dev_acc(1'b0, ADDR_MCTL, 8'h4B, r);
    sw_wr(C_CTRL, 8'h03);
    cyc(12 * BAUD_DIV);
    chk(pin_flags(), 8'h0E);
    sw_wr(C_CTRL, 8'h01);
    sw_wr(C_CTRL, 8'h00);
    dev_acc(1'b1, ADDR_MCTL, 8'h00, r);
    chk(r, 8'h00);
    chk(pin_flags(), 8'h0E);
    sw_wr(C_CTRL, 8'h40);
    dev_acc(1'b0, ADDR_IEN, 8'h3C, r);
    dev_acc(1'b1, ADDR_IEN, 8'h00, r);
    sw_wr(C_CTRL, 8'h00);
    dev_acc(1'b1, ADDR_IEN, 8'h00, r);
    chk(r, 8'h00);
    dev_acc(1'b0, ADDR_IEN, 8'h01, r);
    dev_acc(1'b0, ADDR_MCTL, 8'h08, r);
    sw_wr(C_STAT, 8'hFF);
    v = 8'($urandom());
    put_frame(v);
    cyc(BAUD_DIV);
    chk({6'h00, rx_valid_out, upi_if_i.irq}, 8'h03);
    chk(rx_data_out, v);
    sw_rd(C_STAT, r);
    chk({6'h00, r[ST_INT_BIT], irq_out}, 8'h03);
    sw_wr(C_MASK, 8'hFF);
    chk({7'h00, irq_out}, 8'h00);
    sw_wr(C_MASK, 8'h00);
    sw_wr(C_STAT, 8'hFF);
    chk({7'h00, irq_out}, 8'h00);
    dev_acc(1'b1, ADDR_DATA, 8'h00, r);
    chk(r, v);
    chk({6'h00, rx_valid_out, upi_if_i.irq}, 8'h00);
    conclude();
  end
endmodule : tb
